// file: core/uvpil_regs.sv
// undervoltage, line-impedance and load-line configuration bank with flags and interrupt
// Functional notes
// - on a flag shutdown the auxiliary pwm output stops at once regardless of bit 7.
// - with bit 7 of the undervoltage register set the other pwm outputs stop at cycle end.
// - bit 7 only acts when the auxiliary pwm output is the regulating output.
// - the 7-bit undervoltage field sets a threshold of field/128 times 1.55 V.
// - the 8-bit line-impedance limit is compared with the measured impedance reading.
// - a reading above the limit sets bit 2 of the flag register at 0x02.
// - bit 3 of the load-line register enables droop; when clear there is no droop.
// - the 3-bit load-line code selects droop from 51.5 mohm down to zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "uvpil_defs.svh"
module uvpil_regs
  import uvpil_pkg::*;
#(
  parameter int ADDR_W = `UVPIL_ADDR_W,
  parameter int DATA_W = `UVPIL_DATA_W
) (
  // clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      clk_en,
  // register port
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [DATA_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [DATA_W-1:0]         reg_rdata,
  // measurements and power-stage status
  input  wire logic [7:0]                line_impedance_value,
  input  wire logic                      fault_shutdown,
  input  wire logic                      aux_regulates,
  input  wire logic                      cycle_end,
  // pwm enables
  output logic                           aux_pwm_output_en,
  output logic                           main_pwm_en,
  // protection and load-line settings
  output logic [`UVPIL_UV_FIELD_MSB:0]   undervoltage_protection_code,
  output logic [`UVPIL_THR_W-1:0]        undervoltage_protection_mv,
  output logic                           line_impedance_flag,
  output logic                           load_line_enable,
  output logic [`UVPIL_DROOP_W-1:0]      load_line_droop,
  // interrupt
  output logic                           irq
);

  // droop in units of 10 micro-ohm for a load-line code
  function automatic logic [`UVPIL_DROOP_W-1:0] droop_of(input logic [2:0] code);
    case (code)
      3'h0:    droop_of = `UVPIL_DROOP_CODE0;
      3'h1:    droop_of = `UVPIL_DROOP_CODE1;
      3'h2:    droop_of = `UVPIL_DROOP_CODE2;
      3'h3:    droop_of = `UVPIL_DROOP_CODE3;
      3'h4:    droop_of = `UVPIL_DROOP_CODE4;
      3'h5:    droop_of = `UVPIL_DROOP_CODE5;
      3'h6:    droop_of = `UVPIL_DROOP_CODE6;
      default: droop_of = `UVPIL_DROOP_CODE7;
    endcase
  endfunction : droop_of

  // address match used by both the write and read decoders
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  uvpil_byte_t sense1_undervoltage_limit;
  uvpil_byte_t line_impedance_limit;
  uvpil_byte_t load_line_impedance;
  uvpil_byte_t flags;
  uvpil_byte_t irq_mask;
  uvpil_byte_t next_flags;
  uvpil_byte_t flag_events;
  uvpil_byte_t flag_clear;
  uvpil_byte_t rd_mux;

  logic                          wr_uv;
  logic                          wr_lim;
  logic                          wr_ll;
  logic                          wr_flags;
  logic                          wr_mask;
  logic                          imp_over;
  logic                          aux_en_int;
  logic                          main_en_int;
  logic [`UVPIL_UV_PROD_W-1:0]   uv_product;
  logic [`UVPIL_THR_W-1:0]       uv_mv;
  logic [`UVPIL_DROOP_W-1:0]     droop_sel;

  // write decode
  assign wr_uv    = reg_wr && hit(reg_addr, `UVPIL_OFF_UV_LIMIT);
  assign wr_lim   = reg_wr && hit(reg_addr, `UVPIL_OFF_LINE_IMP_LIM);
  assign wr_ll    = reg_wr && hit(reg_addr, `UVPIL_OFF_LOAD_LINE);
  assign wr_flags = reg_wr && hit(reg_addr, `UVPIL_OFF_FLAGS);
  assign wr_mask  = reg_wr && hit(reg_addr, `UVPIL_OFF_IRQ_MASK);

  // undervoltage threshold in millivolts, field/128 of full scale
  assign uv_product = `UVPIL_UV_PROD_W'(sense1_undervoltage_limit[`UVPIL_UV_FIELD_MSB:0])
                      * `UVPIL_UV_PROD_W'(`UVPIL_UV_FULL_MV);
  assign uv_mv      = `UVPIL_THR_W'(uv_product >> `UVPIL_UV_STEPS_LOG2);

  // line-impedance comparison against the programmed limit
  assign imp_over = line_impedance_value > line_impedance_limit;

  // flag events; set wins over a write-one clear in the same cycle
  always_comb begin
    flag_events = 8'h00;
    flag_events[`UVPIL_BIT_FLAG_LINE_IMP] = imp_over;
    flag_events[`UVPIL_BIT_FLAG_SHUTDOWN] = fault_shutdown;
  end

  assign flag_clear = wr_flags ? reg_wdata : 8'h00;
  assign next_flags = ((flags & ~flag_clear) | flag_events) & `UVPIL_FLAG_USED_MASK;

  // droop disabled gives no lowering of the target
  assign droop_sel = load_line_impedance[`UVPIL_BIT_LL_ENABLE]
                     ? droop_of(load_line_impedance[`UVPIL_LL_FIELD_MSB:0])
                     : `UVPIL_DROOP_CODE7;

  // read selection
  assign rd_mux = hit(reg_addr, `UVPIL_OFF_UV_LIMIT)     ? sense1_undervoltage_limit :
                  hit(reg_addr, `UVPIL_OFF_LINE_IMP_LIM) ? line_impedance_limit :
                  hit(reg_addr, `UVPIL_OFF_LOAD_LINE)    ? load_line_impedance :
                  hit(reg_addr, `UVPIL_OFF_FLAGS)        ? flags :
                  hit(reg_addr, `UVPIL_OFF_IRQ_MASK)     ? irq_mask :
                  hit(reg_addr, `UVPIL_OFF_LINE_IMP_VAL) ? line_impedance_value :
                  8'h00;

  // undervoltage limit and end-of-cycle select
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sense1_undervoltage_limit <= `UVPIL_RST_UV_LIMIT;
    end else if (clk_en && wr_uv) begin
      sense1_undervoltage_limit <= reg_wdata;
    end
  end

  // line-impedance limit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_impedance_limit <= `UVPIL_RST_LINE_IMP_LIM;
    end else if (clk_en && wr_lim) begin
      line_impedance_limit <= reg_wdata;
    end
  end

  // load-line register, upper nibble kept as written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      load_line_impedance <= `UVPIL_RST_LOAD_LINE;
    end else if (clk_en && wr_ll) begin
      load_line_impedance <= reg_wdata;
    end
  end

  // sticky flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags <= `UVPIL_RST_FLAGS;
    end else if (clk_en) begin
      flags <= next_flags;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask <= `UVPIL_RST_IRQ_MASK;
    end else if (clk_en && wr_mask) begin
      irq_mask <= reg_wdata & `UVPIL_FLAG_USED_MASK;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // registered copies of derived settings
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      undervoltage_protection_code <= '0;
      undervoltage_protection_mv   <= '0;
      load_line_enable             <= 1'b0;
      load_line_droop              <= '0;
      line_impedance_flag          <= 1'b0;
      irq                          <= 1'b0;
      aux_pwm_output_en            <= 1'b0;
      main_pwm_en                  <= 1'b0;
    end else if (clk_en) begin
      undervoltage_protection_code <= sense1_undervoltage_limit[`UVPIL_UV_FIELD_MSB:0];
      undervoltage_protection_mv   <= uv_mv;
      load_line_enable             <= load_line_impedance[`UVPIL_BIT_LL_ENABLE];
      load_line_droop              <= droop_sel;
      line_impedance_flag          <= next_flags[`UVPIL_BIT_FLAG_LINE_IMP];
      irq                          <= |(next_flags & irq_mask);
      aux_pwm_output_en            <= aux_en_int;
      main_pwm_en                  <= main_en_int;
    end
  end

  uvpil_shutdown u_shutdown (
    .sys_clk           (sys_clk),
    .srst              (srst),
    .clk_en            (clk_en),
    .fault_shutdown    (fault_shutdown),
    .end_of_cycle_sel  (sense1_undervoltage_limit[`UVPIL_BIT_EOC_SHUTDOWN]),
    .aux_regulates     (aux_regulates),
    .cycle_end         (cycle_end),
    .aux_pwm_output_en (aux_en_int),
    .main_pwm_en       (main_en_int)
  );

endmodule : uvpil_regs

// file: include/uvpil_defs.svh
// register offsets, field positions, reset values and scaling constants of the bank
`ifndef UVPIL_DEFS_SVH
`define UVPIL_DEFS_SVH

`define UVPIL_ADDR_W            8
`define UVPIL_DATA_W            8

`define UVPIL_OFF_FLAGS         8'h02
`define UVPIL_OFF_LINE_IMP_VAL  8'h1F
`define UVPIL_OFF_UV_LIMIT      8'h34
`define UVPIL_OFF_LINE_IMP_LIM  8'h35
`define UVPIL_OFF_LOAD_LINE     8'h36
`define UVPIL_OFF_IRQ_MASK      8'h3D

`define UVPIL_RST_UV_LIMIT      8'h00
`define UVPIL_RST_LINE_IMP_LIM  8'h00
`define UVPIL_RST_LOAD_LINE     8'h00
`define UVPIL_RST_FLAGS         8'h00
`define UVPIL_RST_IRQ_MASK      8'h00

`define UVPIL_BIT_EOC_SHUTDOWN  7
`define UVPIL_UV_FIELD_MSB      6
`define UVPIL_BIT_LL_ENABLE     3
`define UVPIL_LL_FIELD_MSB      2
`define UVPIL_BIT_FLAG_SHUTDOWN 0
`define UVPIL_BIT_FLAG_LINE_IMP 2
`define UVPIL_FLAG_USED_MASK    8'h05

`define UVPIL_UV_FULL_MV        11'h60E
`define UVPIL_UV_STEPS_LOG2     7
`define UVPIL_UV_PROD_W         18
`define UVPIL_THR_W             11

`define UVPIL_DROOP_W           13
`define UVPIL_DROOP_CODE0       13'h141E
`define UVPIL_DROOP_CODE1       13'h0A28
`define UVPIL_DROOP_CODE2       13'h04E2
`define UVPIL_DROOP_CODE3       13'h0271
`define UVPIL_DROOP_CODE4       13'h012C
`define UVPIL_DROOP_CODE5       13'h0096
`define UVPIL_DROOP_CODE6       13'h0046
`define UVPIL_DROOP_CODE7       13'h0000

`endif

// file: include/uvpil_pkg.sv
// types shared by the undervoltage, line-impedance and load-line register bank
package uvpil_pkg;
  typedef logic [7:0] uvpil_byte_t;
  typedef enum logic [1:0] {
    UVPIL_RUN,
    UVPIL_DRAIN,
    UVPIL_HALT
  } uvpil_sd_state_t;
endpackage : uvpil_pkg

// file: core/uvpil_shutdown.sv
// pwm shutdown sequencing after a flag shutdown
`timescale 1ns/1ps
`include "uvpil_defs.svh"
module uvpil_shutdown
  import uvpil_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  // control
  input  wire logic fault_shutdown,
  input  wire logic end_of_cycle_sel,
  input  wire logic aux_regulates,
  input  wire logic cycle_end,
  // pwm enables
  output logic      aux_pwm_output_en,
  output logic      main_pwm_en
);
  uvpil_sd_state_t state;
  uvpil_sd_state_t next_state;
  logic            wait_cycle_end;

  assign wait_cycle_end = end_of_cycle_sel & aux_regulates;

  always_comb begin
    next_state = state;
    case (state)
      UVPIL_RUN: begin
        if (fault_shutdown) begin
          if (wait_cycle_end && !cycle_end) begin
            next_state = UVPIL_DRAIN;
          end else begin
            next_state = UVPIL_HALT;
          end
        end
      end
      UVPIL_DRAIN: begin
        if (cycle_end) begin
          next_state = UVPIL_HALT;
        end
      end
      UVPIL_HALT: begin
        if (!fault_shutdown) begin
          next_state = UVPIL_RUN;
        end
      end
      default: next_state = UVPIL_HALT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state             <= UVPIL_HALT;
      aux_pwm_output_en <= 1'b0;
      main_pwm_en       <= 1'b0;
    end else if (clk_en) begin
      state             <= next_state;
      aux_pwm_output_en <= !fault_shutdown && next_state == UVPIL_RUN;
      main_pwm_en       <= next_state != UVPIL_HALT;
    end
  end
endmodule : uvpil_shutdown

// file: sim/uvpil_regs_properties.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
`include "uvpil_defs.svh"
module uvpil_regs_properties #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  // clock, reset, enable
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire logic                    clk_en,
  // register port
  input wire logic [ADDR_W-1:0]       reg_addr,
  input wire logic [DATA_W-1:0]       reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [DATA_W-1:0]       reg_rdata,
  // power stage
  input wire logic                    fault_shutdown,
  input wire logic                    aux_regulates,
  input wire logic                    cycle_end,
  input wire logic                    aux_pwm_output_en,
  input wire logic                    main_pwm_en,
  // settings and interrupt
  input wire logic                    line_impedance_flag,
  input wire logic                    load_line_enable,
  input wire logic [`UVPIL_DROOP_W-1:0] load_line_droop,
  input wire logic                    irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic eoc;
  logic mask2;
  // shadows of the end-of-cycle bit and the line-impedance mask bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      eoc   <= 1'b0;
      mask2 <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == 8'h34) begin
      eoc <= reg_wdata[7];
    end else if (clk_en && reg_wr && reg_addr == 8'h3D) begin
      mask2 <= reg_wdata[2];
    end
  end
  AST_RDATA_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  AST_LIF_STICKY: assert property (
    line_impedance_flag && clk_en && !reg_wr |=> line_impedance_flag)
    else $error("line impedance flag dropped without clear");
  AST_IRQ_FLAG: assert property (line_impedance_flag && mask2 |-> ##[0:1] irq)
    else $error("irq missing for unmasked flag");
  AST_AUX_STOP: assert property (
    $rose(fault_shutdown) && aux_pwm_output_en |-> ##[1:2] !aux_pwm_output_en)
    else $error("aux pwm not stopped at once");
  AST_MAIN_IMMED: assert property (
    $rose(fault_shutdown) && main_pwm_en && !(eoc && aux_regulates) |-> ##[1:2] !main_pwm_en)
    else $error("main pwm not stopped at once");
  AST_MAIN_HOLD: assert property (
    $rose(fault_shutdown) && eoc && aux_regulates && main_pwm_en && !cycle_end
    |=> main_pwm_en [*2])
    else $error("main pwm stopped before cycle end");
  AST_MAIN_END: assert property (
    fault_shutdown && cycle_end && main_pwm_en |-> ##[1:2] !main_pwm_en)
    else $error("main pwm still running after cycle end");
  AST_LL_OFF: assert property (!load_line_enable |-> load_line_droop == 13'h0000)
    else $error("droop present while load line disabled");
  COV_FAULT: cover property ($rose(fault_shutdown));
  COV_LIF: cover property ($rose(line_impedance_flag));
  COV_IRQ: cover property ($rose(irq));
endmodule : uvpil_regs_properties

// file: sim/uvpil_regs_tb.sv
// self-checking testbench of the register bank
`timescale 1ns/1ps
module uvpil_regs_tb;
  logic sys_clk = 0, srst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, liv = 0, d;
  logic fault = 0, auxr = 0, cyc = 0, aux_en, main_en, lif, lle, irq;
  logic [6:0] uvc;
  logic [10:0] uvmv;
  logic [12:0] droop;
  logic [12:0] dtab [8] = '{13'h141E, 13'h0A28, 13'h04E2, 13'h0271,
                            13'h012C, 13'h0096, 13'h0046, 13'h0000};
  logic [7:0] rst_addr [5] = '{8'h34, 8'h35, 8'h36, 8'h3D, 8'h02};
  int err_count = 0, n_compared = 0, cycles = 0;
  uvpil_regs DUT (.sys_clk, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .line_impedance_value(liv), .fault_shutdown(fault), .aux_regulates(auxr),
    .cycle_end(cyc), .aux_pwm_output_en(aux_en), .main_pwm_en(main_en),
    .undervoltage_protection_code(uvc), .undervoltage_protection_mv(uvmv),
    .line_impedance_flag(lif), .load_line_enable(lle), .load_line_droop(droop), .irq);
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_n
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    wait_n(12);
    srst <= 0;
    wait_n(3);
    foreach (rst_addr[i]) begin
      rd(rst_addr[i]);
      chk(d, 0);
    end
    chk(main_en, 1);
    chk(uvc, 0);
    chk(uvmv, 0);
    chk(irq, 0);
    chk(droop, 0);
    $display("test reset done");
    wr(8'h34, 8'h3C);
    wr(8'h35, 8'h80);
    wr(8'h36, 8'hA5);
    wr(8'h1F, 8'hFF);
    liv <= 8'h40;
    rd(8'h34);
    chk(d, 8'h3C);
    rd(8'h35);
    chk(d, 8'h80);
    rd(8'h36);
    chk(d, 8'hA5);
    rd(8'h1F);
    chk(d, 8'h40);
    rd(8'h50);
    chk(d, 0);
    chk(uvc, 7'h3C);
    chk(uvmv, 11'h2D6);
    chk(lle, 0);
    chk(droop, 0);
    clk_en <= 0;
    wr(8'h35, 8'h11);
    clk_en <= 1;
    rd(8'h35);
    chk(d, 8'h80);
    wr(8'h34, 8'h52);
    wait_n(2);
    chk(uvc, 7'h52);
    chk(uvmv, 11'h3E0);
    $display("test access done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h36, 8'hF8 | i[7:0]);
      wait_n(2);
      chk(droop, dtab[i]);
      chk(lle, 1);
    end
    $display("test droop done");
    liv <= 8'h80;
    wait_n(3);
    chk(lif, 0);
    liv <= 8'h81;
    wait_n(3);
    chk(lif, 1);
    chk(irq, 0);
    wr(8'h02, 8'h04);
    wait_n(1);
    chk(lif, 1);
    rd(8'h02);
    chk(d, 8'h04);
    wr(8'h3D, 8'h04);
    wait_n(2);
    chk(irq, 1);
    liv <= 8'h10;
    wr(8'h02, 8'h04);
    wait_n(2);
    chk(lif, 0);
    chk(irq, 0);
    $display("test line impedance done");
    for (int m = 0; m < 3; m++) begin
      wr(8'h34, (m > 0) ? 8'hBC : 8'h3C);
      auxr  <= (m != 1);
      fault <= 1;
      wait_n(3);
      chk(aux_en, 0);
      chk(main_en, m == 2);
      cyc <= 1;
      wait_n(1);
      cyc <= 0;
      wait_n(3);
      chk(main_en, 0);
      fault <= 0;
      wr(8'h02, 8'h05);
      wait_n(4);
      chk(aux_en, 1);
      chk(main_en, 1);
    end
    $display("test shutdown done");
    tally_and_finish();
  end
endmodule : uvpil_regs_tb
bind uvpil_regs uvpil_regs_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .sys_clk, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .fault_shutdown, .aux_regulates, .cycle_end, .aux_pwm_output_en, .main_pwm_en,
  .line_impedance_flag, .load_line_enable, .load_line_droop, .irq);
